// file: logic/madbr_bootsel.sv
`timescale 1ns/100ps
module madbr_bootsel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Boot strap and remap control
  input wire logic boot_select_pin_i,
  input wire logic remap_set_i,
  input wire logic remap_clr_i,
  // Map state
  output logic boot_rom_o,
  output logic boot_ok_o,
  output logic remap_o
);
  import madbr_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic boot_rom_r;
  logic boot_ok_r;
  logic remap_r;
  logic remap_nxt;
  logic agree;

  // Pin level counts only once the last two stages agree
  assign agree = (sync2_r == sync3_r);
  // Set wins over a clear in the same cycle
  assign remap_nxt = remap_set_i | (remap_r & ~remap_clr_i);

  // Three-stage synchroniser without reset; the strap is sampled under reset too
  always_ff @(posedge clk_i) begin
    sync1_r <= boot_select_pin_i;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  // Strap caught once after release, then frozen until the next reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      boot_rom_r <= RST_BOOT_ROM;
      boot_ok_r <= 1'b0;
      remap_r <= RST_REMAP;
    end else begin
      if (!boot_ok_r && agree) begin
        boot_rom_r <= sync3_r;
        boot_ok_r <= 1'b1;
      end
      remap_r <= remap_nxt;
    end
  end

  assign boot_rom_o = boot_rom_r;
  assign boot_ok_o = boot_ok_r;
  assign remap_o = remap_r;
endmodule

// file: logic/madbr_mdec.sv
`timescale 1ns/100ps
module madbr_mdec #(
  parameter logic [5:0] ACCESS = 6'h3f,
  parameter logic HAS_BOOT = 1'b0
) (
  // Request address
  input wire logic [31:0] addr_i,
  // Boot map state
  input wire logic boot_rom_i,
  input wire logic boot_ok_i,
  input wire logic remap_i,
  // Decode result
  output madbr_pkg::madbr_dec_t dec_o
);
  import madbr_pkg::*;

  logic [3:0] bank;
  logic [7:0] area;
  logic [19:0] low;
  logic in_int;
  logic in_ext;
  logic in_per;
  logic boot_area;
  logic boot_sram;
  logic boot_rom;
  logic boot_ext;
  logic [5:0] raw;
  logic [2:0] cs;
  logic [31:0] offs;

  // Address fields: bank, 1 Mbyte area, offset in area
  assign bank = addr_i[BANK_MSB:BANK_LSB];
  assign area = addr_i[AREA_MSB:AREA_LSB];
  assign low = addr_i[AREA_LSB-1:0];
  assign in_int = (bank == BANK_INTERNAL);
  assign in_ext = (bank >= BANK_EXT_FIRST) && (bank <= BANK_EXT_LAST);
  assign in_per = (bank == BANK_PERIPH);

  // Boot area only for the processor ports, once the strap is known
  assign boot_area = HAS_BOOT && boot_ok_i && in_int && (area == AREA_BOOT);
  assign boot_sram = boot_area && remap_i && (low < SIZE_SRAM);
  assign boot_rom = boot_area && !remap_i && boot_rom_i && (low < SIZE_ROM);
  assign boot_ext = boot_area && !remap_i && !boot_rom_i;

  // Fixed areas stay visible whatever the boot map says; holes miss
  assign raw[SLV_FIRST_INTERNAL_SRAM] = boot_sram
    || (in_int && (area == AREA_FIRST_INTERNAL_SRAM) && (low < SIZE_SRAM));
  assign raw[SLV_SECOND_SRAM] = in_int && (area == AREA_SRAM1) && (low < SIZE_SRAM);
  assign raw[SLV_ROM] = boot_rom || (in_int && (area == AREA_ROM) && (low < SIZE_ROM));
  assign raw[SLV_USB_REGS] = in_int && (area == AREA_USB_REGS) && (low < SIZE_USB_REGS);
  assign raw[SLV_EXTERNAL_BUS_IFACE] = in_ext || boot_ext;
  assign raw[SLV_PERIPH] = in_per;

  // Each chip select owns one 256 Mbyte bank; boot from chip select zero
  assign cs = in_ext ? 3'(bank - BANK_EXT_FIRST) : 3'h0;
  assign offs = (in_ext || in_per) ? {4'h0, addr_i[AREA_MSB:0]} : {12'h000, low};

  // Forbidden paths are simply not wired
  always_comb begin
    dec_o.tgt = raw & ACCESS;
    dec_o.hit = |(raw & ACCESS);
    dec_o.cs = cs;
    dec_o.offs = offs;
  end
endmodule

// file: logic/madbr_pkg.sv
package madbr_pkg;

  // Matrix dimensions
  localparam int unsigned NMST = 6;
  localparam int unsigned NSLV = 6;

  // Master indices
  localparam logic [2:0] MST_CPU_INSTR = 3'h0;
  localparam logic [2:0] MST_CPU_DATA = 3'h1;
  localparam logic [2:0] MST_PERIPHERAL_DMA_ENGINE = 3'h2;
  localparam logic [2:0] MST_USB_HOST_PORT = 3'h3;
  localparam logic [2:0] MST_IMAGE_SENSOR_IFACE = 3'h4;
  localparam logic [2:0] MST_ETH_MAC = 3'h5;

  // Slave port indices, one bit each in a target vector
  localparam int unsigned SLV_FIRST_INTERNAL_SRAM = 0;
  localparam int unsigned SLV_SECOND_SRAM = 1;
  localparam int unsigned SLV_ROM = 2;
  localparam int unsigned SLV_USB_REGS = 3;
  localparam int unsigned SLV_EXTERNAL_BUS_IFACE = 4;
  localparam int unsigned SLV_PERIPH = 5;

  // First decoding level: 16 banks of 256 Mbytes on addr[31:28]
  localparam int unsigned BANK_MSB = 31;
  localparam int unsigned BANK_LSB = 28;
  localparam logic [3:0] BANK_INTERNAL = 4'h0;
  localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [3:0] BANK_EXT_LAST = 4'h7;
  localparam logic [3:0] BANK_PERIPH = 4'hf;

  // Second decoding level in bank zero: 1 Mbyte areas on addr[27:20]
  localparam int unsigned AREA_MSB = 27;
  localparam int unsigned AREA_LSB = 20;
  localparam logic [7:0] AREA_BOOT = 8'h00;
  localparam logic [7:0] AREA_ROM = 8'h01;
  localparam logic [7:0] AREA_FIRST_INTERNAL_SRAM = 8'h02;
  localparam logic [7:0] AREA_SRAM1 = 8'h03;
  localparam logic [7:0] AREA_USB_REGS = 8'h05;

  // Populated size of each internal memory inside its 1 Mbyte area
  localparam logic [19:0] SIZE_ROM = 20'h08000;
  localparam logic [19:0] SIZE_SRAM = 20'h01000;
  localparam logic [19:0] SIZE_USB_REGS = 20'h04000;

  // Allowed master-to-slave paths, bit per slave port
  localparam logic [5:0] ACC_CPU = 6'h3f;
  localparam logic [5:0] ACC_DMA = 6'h37;
  localparam logic [5:0] ACC_VIDEO_NET = 6'h13;

  // Reset values
  localparam logic RST_REMAP = 1'b0;
  localparam logic RST_BOOT_ROM = 1'b1;

  // Master request and answer
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } madbr_mreq_t;

  typedef struct packed {
    logic grant;
    logic abort;
  } madbr_mrsp_t;

  // Decoder result of one master
  typedef struct packed {
    logic hit;
    logic [5:0] tgt;
    logic [2:0] cs;
    logic [31:0] offs;
  } madbr_dec_t;

  // Request forwarded to a slave port
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] master;
    logic [2:0] cs;
    logic [31:0] offs;
  } madbr_sreq_t;

endpackage

// file: logic/madbr_top.sv
// Behaviour
// - Top four address bits pick one of sixteen banks
// - Banks one to seven go to external bus
// - Bank zero holds internal memories, 1 Mbyte areas
// - Bank fifteen goes to the peripheral bridge
// - Unmapped access answers the master with abort
// - Every master has its own decoder instance
// - Each chip select owns one 256 Mbyte bank
// - Forbidden master-to-slave paths are never connected
// - Ethernet master never reaches the peripheral bridge
// - Processor ports see a boot slave at zero
// - First megabyte holds the strap-selected boot memory
// - Strap high, no remap: ROM at zero
// - Strap low, no remap: chip select zero
// - Remap puts first internal SRAM at zero
// - Unaffected memories stay at their fixed bases
// - ROM and SRAMs answer in one matrix cycle
// - Masters proceed concurrently when their slaves differ
`timescale 1ns/100ps
module madbr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Boot strap pin and remap control
  input wire logic boot_select_pin_i,
  input wire logic remap_set_i,
  input wire logic remap_clr_i,
  // Master side
  input wire madbr_pkg::madbr_mreq_t mst_req_i [6],
  output madbr_pkg::madbr_mrsp_t mst_rsp_o [6],
  // Slave side
  input wire logic [5:0] slv_rdy_i,
  output madbr_pkg::madbr_sreq_t slv_req_o [6],
  // Map state
  output logic boot_rom_o,
  output logic boot_ok_o,
  output logic remap_o
);
  import madbr_pkg::*;

  // Access map per master, indexed by master number
  localparam logic [5:0] ACC_MAP [6] = '{ACC_CPU, ACC_CPU, ACC_DMA, ACC_DMA,
    ACC_VIDEO_NET, ACC_VIDEO_NET};

  logic boot_rom;
  logic boot_ok;
  logic remap;
  madbr_dec_t dec [6];
  logic [5:0] want [6];
  logic [5:0] won [6];
  logic [5:0] grant;
  logic [5:0] miss;
  logic [5:0] abort_r;
  logic [5:0] abort_nxt;
  madbr_sreq_t sreq_r [6];
  madbr_sreq_t sreq_nxt [6];

  // Boot strap capture and remap state
  madbr_bootsel u_bootsel (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .boot_select_pin_i(boot_select_pin_i),
    .remap_set_i(remap_set_i),
    .remap_clr_i(remap_clr_i),
    .boot_rom_o(boot_rom),
    .boot_ok_o(boot_ok),
    .remap_o(remap)
  );

  // One decoder per master; only the processor ports carry the boot area
  for (genvar m = 0; m < NMST; m++) begin : g_mst
    madbr_mdec #(
      .ACCESS(ACC_MAP[m]),
      .HAS_BOOT(m < 2)
    ) u_dec (
      .addr_i(mst_req_i[m].addr),
      .boot_rom_i(boot_rom),
      .boot_ok_i(boot_ok),
      .remap_i(remap),
      .dec_o(dec[m])
    );

    // A master asks for the slave its decoder selected
    assign want[m] = mst_req_i[m].valid ? dec[m].tgt : 6'h00;
    // A miss is a request with no reachable slave, except a boot-area
    // access from a processor port while the strap is still settling
    assign miss[m] = mst_req_i[m].valid && !dec[m].hit
      && !((m < 2) && !boot_ok && (mst_req_i[m].addr[BANK_MSB:AREA_LSB] == 12'h000));
  end

  // Fixed priority per slave: lowest master number wins a shared slave.
  // Masters on different slaves never block each other.
  for (genvar s = 0; s < NSLV; s++) begin : g_slv
    for (genvar m = 0; m < NMST; m++) begin : g_arb
      if (m == 0) begin : g_first
        assign won[m][s] = want[m][s] && slv_rdy_i[s];
      end else begin : g_rest
        logic [m-1:0] above;
        for (genvar k = 0; k < m; k++) begin : g_above
          assign above[k] = want[k][s];
        end
        assign won[m][s] = want[m][s] && slv_rdy_i[s] && !(|above);
      end
    end
  end

  // A master is granted when its single target slave went to it
  for (genvar m = 0; m < NMST; m++) begin : g_grant
    assign grant[m] = |won[m];
    assign abort_nxt[m] = miss[m];
    // One driver per answer word, so no field is written twice
    assign mst_rsp_o[m] = '{grant: grant[m], abort: abort_r[m]};
  end

  // Next slave request: the winning master's decoded offset, or idle
  always_comb begin
    for (int s = 0; s < NSLV; s++) begin
      sreq_nxt[s] = '0;
      for (int m = NMST - 1; m >= 0; m--) begin
        if (won[m][s]) begin
          sreq_nxt[s].valid = 1'b1;
          sreq_nxt[s].write = mst_req_i[m].write;
          sreq_nxt[s].master = 3'(m);
          sreq_nxt[s].cs = dec[m].cs;
          sreq_nxt[s].offs = dec[m].offs;
        end
      end
    end
  end

  // One register stage toward every slave keeps the internal memories
  // at a single cycle per access without a combinational path through
  // the arbiters into the memory macros
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int s = 0; s < NSLV; s++) begin
        sreq_r[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NSLV; s++) begin
        sreq_r[s] <= sreq_nxt[s];
      end
    end
  end

  // Abort answer one cycle after the unmapped request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      abort_r <= 6'h00;
    end else begin
      abort_r <= abort_nxt;
    end
  end

  // Slave request outputs
  for (genvar s = 0; s < NSLV; s++) begin : g_sout
    assign slv_req_o[s] = sreq_r[s];
  end

  // Map state for observation
  assign boot_rom_o = boot_rom;
  assign boot_ok_o = boot_ok;
  assign remap_o = remap;
endmodule

// file: tb/madbr_chk.sv
`timescale 1ns/100ps
module madbr_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Strap and remap
  input wire logic boot_select_pin_i,
  input wire logic remap_set_i,
  input wire logic remap_clr_i,
  // Masters
  input wire madbr_pkg::madbr_mreq_t mst_req_i [6],
  input wire madbr_pkg::madbr_mrsp_t mst_rsp_o [6],
  // Slaves
  input wire logic [5:0] slv_rdy_i,
  input wire madbr_pkg::madbr_sreq_t slv_req_o [6],
  // Map state
  input wire logic boot_rom_o,
  input wire logic boot_ok_o,
  input wire logic remap_o
);
  import madbr_pkg::*;
  logic [31:0] a0_r;
  logic [31:0] a1_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Last cycle addresses, so forwarded offsets can be tied to their cause
  always_ff @(posedge clk_i) begin
    a0_r <= mst_req_i[0].addr;
    a1_r <= mst_req_i[1].addr;
  end
  // Map and path checks
  ext_bank_a: assert property (
    mst_rsp_o[1].grant && mst_req_i[1].addr[31:28] inside {[4'h1:4'h7]} |=>
    slv_req_o[4].valid && slv_req_o[4].cs == a1_r[30:28] - 3'h1
    && slv_req_o[4].offs == {4'h0, a1_r[27:0]}) else $error("ext route");
  hole_abort_a: assert property (
    mst_req_i[1].valid && mst_req_i[1].addr[31:28] inside {[4'h8:4'he]} |=>
    mst_rsp_o[1].abort) else $error("hole abort");
  eth_periph_a: assert property (
    mst_req_i[5].valid && mst_req_i[5].addr[31:28] == 4'hf |=> mst_rsp_o[5].abort)
    else $error("eth periph");
  periph_src_a: assert property (
    slv_req_o[5].valid |-> slv_req_o[5].master < 3'h4) else $error("periph src");
  usb_src_a: assert property (
    slv_req_o[3].valid |-> slv_req_o[3].master < 3'h2) else $error("usb src");
  rom_cycle_a: assert property (
    mst_rsp_o[0].grant && mst_req_i[0].addr[31:20] == 12'h001 |=>
    slv_req_o[2].valid && slv_req_o[2].offs[19:0] == a0_r[19:0]) else $error("rom");
  boot_stall_a: assert property (
    mst_req_i[0].valid && mst_req_i[0].addr[31:20] == 12'h000 && !boot_ok_o |->
    !mst_rsp_o[0].grant) else $error("boot stall");
  // Map state checks
  remap_rst_a: assert property (disable iff (1'b0) sys_rst_i |=> !remap_o)
    else $error("remap rst");
  remap_set_a: assert property (remap_set_i |=> remap_o) else $error("remap set");
  strap_hold_a: assert property (
    boot_ok_o |=> $stable(boot_rom_o) && boot_ok_o) else $error("strap hold");
  // Main scenarios
  cover property (mst_rsp_o[1].grant && mst_req_i[1].addr[31:28] == 4'h7);
  cover property (mst_rsp_o[5].abort);
  cover property (remap_o && mst_rsp_o[1].grant);
endmodule
bind madbr_top madbr_chk i_madbr_chk (.clk_i, .sys_rst_i, .boot_select_pin_i,
  .remap_set_i, .remap_clr_i, .mst_req_i, .mst_rsp_o, .slv_rdy_i, .slv_req_o,
  .boot_rom_o, .boot_ok_o, .remap_o);

// file: tb/madbr_slv_model.sv
`timescale 1ns/100ps
module madbr_slv_model (
  // Stall control from the bench
  input wire logic [5:0] hold_i,
  // Slave readiness
  output logic [5:0] slv_rdy_o
);
  // A held slave stays busy as long as the bench likes, to stall masters
  assign slv_rdy_o = ~hold_i;
endmodule

// file: tb/test_madbr_top.sv
`timescale 1ns/100ps
module test_madbr_top;
  import madbr_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic boot_select_pin_i = 1'b1;
  logic remap_set_i = 1'b0;
  logic remap_clr_i = 1'b0;
  logic [5:0] hold = 6'h00;
  logic [5:0] slv_rdy_i;
  logic boot_rom_o;
  logic boot_ok_o;
  logic remap_o;
  madbr_mreq_t mst_req_i [6];
  madbr_mrsp_t mst_rsp_o [6];
  madbr_sreq_t slv_req_o [6];
  int n_mismatch = 0;
  int tests_run = 0;

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  madbr_top i_madbr_top (.clk_i, .sys_rst_i, .boot_select_pin_i, .remap_set_i,
    .remap_clr_i, .mst_req_i, .mst_rsp_o, .slv_rdy_i, .slv_req_o, .boot_rom_o,
    .boot_ok_o, .remap_o);
  madbr_slv_model i_madbr_slv_model (.hold_i(hold), .slv_rdy_o(slv_rdy_i));

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One access by master m; slave 7 means an abort is expected
  task automatic acc(int m, logic [31:0] a, int s, logic [2:0] cs, logic [31:0] o);
    int k;
    logic ab;
    k = 0;
    ab = 1'b0;
    @(negedge clk_i);
    mst_req_i[m] = {1'b1, 1'b0, a};
    #1;
    while (mst_rsp_o[m].grant !== 1'b1 && !ab) begin
      @(negedge clk_i);
      // Let stall changes made at this edge settle before looking
      #1;
      ab = mst_rsp_o[m].abort;
      k++;
      if (k > 20) begin
        n_mismatch++;
        close_out();
      end
    end
    if (!ab) begin
      @(posedge clk_i);
      @(negedge clk_i);
    end
    mst_req_i[m].valid = 1'b0;
    chk("abort", mst_rsp_o[m].abort, s == 7);
    if (s < 7) begin
      chk("valid", slv_req_o[s].valid, 1);
      chk("master", slv_req_o[s].master, m);
      chk("cs", slv_req_o[s].cs, cs);
      chk("offs", slv_req_o[s].offs, o);
    end
  endtask

  // Strap must be stable well before release, so it is set with reset
  task automatic rst(logic pin);
    int k;
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    boot_select_pin_i = pin;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    // A boot-area fetch before the strap is known must wait, not abort
    mst_req_i[0] = {1'b1, 1'b0, 32'h0000_0040};
    #1;
    chk("remap", remap_o, 0);
    chk("stall", mst_rsp_o[0].grant, 0);
    k = 0;
    while (boot_ok_o !== 1'b1 && k < 10) begin
      @(negedge clk_i);
      k++;
    end
    mst_req_i[0].valid = 1'b0;
    if (boot_ok_o !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
    chk("no abort", mst_rsp_o[0].abort, 0);
    chk("strap", boot_rom_o, pin);
  endtask

  task automatic t_boot();
    rst(1'b1);
    acc(0, 32'h0000_0100, 2, 0, 32'h100);
    acc(2, 32'h0000_0000, 7, 0, 0);
    @(negedge clk_i);
    remap_set_i = 1'b1;
    @(negedge clk_i);
    remap_set_i = 1'b0;
    chk("remap", remap_o, 1);
    acc(1, 32'h0000_0ffc, 0, 0, 32'hffc);
    acc(1, 32'h0010_0004, 2, 0, 32'h4);
    remap_clr_i = 1'b1;
    @(negedge clk_i);
    remap_clr_i = 1'b0;
    acc(0, 32'h0000_0010, 2, 0, 32'h10);
    rst(1'b0);
    acc(0, 32'h000f_fff0, 4, 0, 32'hf_fff0);
    acc(1, 32'h0020_0010, 0, 0, 32'h10);
    $display("test boot done");
  endtask

  task automatic t_map();
    for (int b = 1; b < 8; b++) acc(1, {b[3:0], 28'h10}, 4, 3'(b - 1), 32'h10);
    for (int b = 8; b < 15; b++) acc(1, {b[3:0], 28'h0}, 7, 0, 0);
    acc(2, 32'hfffa_0000, 5, 0, 32'h0ffa_0000);
    acc(5, 32'hf000_0000, 7, 0, 0);
    acc(4, 32'h0010_0000, 7, 0, 0);
    acc(3, 32'h0050_0000, 7, 0, 0);
    acc(0, 32'h0050_0010, 3, 0, 32'h10);
    acc(4, 32'h0030_0ffc, 1, 0, 32'hffc);
    acc(5, 32'h0020_0000, 0, 0, 0);
    acc(1, 32'h0040_0000, 7, 0, 0);
    acc(1, 32'h0020_1000, 7, 0, 0);
    $display("test map done");
  endtask

  task automatic t_conc();
    @(negedge clk_i);
    mst_req_i[0] = {1'b1, 1'b0, 32'h0010_0008};
    mst_req_i[4] = {1'b1, 1'b1, 32'h0030_0008};
    #1;
    chk("grants", {mst_rsp_o[0].grant, mst_rsp_o[4].grant}, 2'b11);
    @(negedge clk_i);
    mst_req_i[0].valid = 1'b0;
    mst_req_i[4].valid = 1'b0;
    chk("both", {slv_req_o[2].valid, slv_req_o[1].valid}, 2'b11);
    chk("write", slv_req_o[1].write, 1);
    chk("wmaster", slv_req_o[1].master, 4);
    // Two masters on one slave: the lower number goes first, the other waits
    @(negedge clk_i);
    mst_req_i[0] = {1'b1, 1'b0, 32'h0030_0004};
    mst_req_i[1] = {1'b1, 1'b0, 32'h0030_0008};
    #1;
    chk("prio", {mst_rsp_o[0].grant, mst_rsp_o[1].grant}, 2'b10);
    @(negedge clk_i);
    mst_req_i[0].valid = 1'b0;
    chk("first", slv_req_o[1].master, 0);
    @(negedge clk_i);
    mst_req_i[1].valid = 1'b0;
    chk("second", slv_req_o[1].master, 1);
    chk("soffs", slv_req_o[1].offs, 32'h8);
    fork
      acc(0, 32'h0010_0020, 2, 0, 32'h20);
      begin
        hold = 6'h04;
        repeat (3) @(negedge clk_i);
        hold = 6'h00;
      end
    join
    $display("test concurrent done");
  endtask

  initial begin
    for (int i = 0; i < 6; i++) mst_req_i[i] = '0;
    t_boot();
    t_map();
    t_conc();
    close_out();
  end
endmodule
